// ===== src/occr_consts.vh
`ifndef OCCR_CONSTS_VH
`define OCCR_CONSTS_VH

// register offsets on the control port
`define OCCR_SOFT_RESET 8'h0A
`define OCCR_PERF_MON 8'h0B
`define OCCR_LOOPBACK_SELECT 8'h0C
`define OCCR_LOSS_ALARM_STANDARD_SELECT 8'h0D
`define OCCR_AUTO_ALL_ONES_ENABLE 8'h0E
`define OCCR_GLOBAL_CONTROL 8'h0F
`define OCCR_WAVE_PHASE_ADDR 8'h17

// reset value of every register in the group
`define OCCR_REG_RESET 8'h00

// global control fields
`define OCCR_GC_AUTO_INC 7
`define OCCR_GC_RX_ALARM_INSERT_EN 6
`define OCCR_GC_RSVD 5
`define OCCR_GC_LINE_CODE_SELECT 4
`define OCCR_GC_FIFO_LEN 3
`define OCCR_GC_JA_CORNER_SEL 2
`define OCCR_GC_JA_POS_HI 1
`define OCCR_GC_JA_POS_LO 0
// writable bits of global control, bit 5 reserved
`define OCCR_GC_MASK 8'hDF

// jitter attenuator position codes
`define OCCR_JA_POS_TX 2'b01
`define OCCR_JA_POS_OFF 2'b10
`define OCCR_JA_POS_RX 2'b11

// performance monitor select field
`define OCCR_PM_MASK 8'h0F
`define OCCR_PM_TX_BIT 3

// phase sample portion of the waveform phase address register
`define OCCR_PHASE_MSB 4
`define OCCR_PHASE_MASK 8'h1F

// jitter attenuator fifo depths in bits
`define OCCR_FIFO_SHORT 7'h20
`define OCCR_FIFO_LONG 7'h40

`endif

// ===== src/occr_chan.v
`timescale 1ns/1ps
// per channel steering, outputs registered
module occr_chan
(
  input wire mclk,
  input wire rst,
  input wire e1_mode,
  input wire loopback_bit,
  input wire standard_bit,
  input wire all_ones_bit,
  input wire rx_alarm_insert_en,
  input wire los,
  output reg loopback_en,
  output reg los_std_etsi,
  output reg transmit_all_ones,
  output reg rx_ais_insert
);

  always @(posedge mclk)
  begin
    if (rst)
    begin
      loopback_en <= 1'b0;
      los_std_etsi <= 1'b0;
      transmit_all_ones <= 1'b0;
      rx_ais_insert <= 1'b0;
    end
    else
    begin
      loopback_en <= loopback_bit; // RULE1
      // t1/j1 always uses the t1.231 criteria, so the bit is masked
      los_std_etsi <= e1_mode & standard_bit; // RULE3 RULE4
      transmit_all_ones <= all_ones_bit & los; // RULE5
      rx_ais_insert <= rx_alarm_insert_en & los; // RULE9
    end
  end

endmodule

// ===== src/occr_regs.v
// Operation
// RULE1: a one in loopback bit n puts channel n in digital loopback.
// RULE2: every register here resets to zero on power-up or any reset.
// RULE3: in t1/j1 mode the standard bit is ignored, t1.231 criteria used.
// RULE4: in e1 mode bit n one selects etsi, zero selects g.775.
// RULE5: auto all ones bit plus loss of signal sends all ones.
// RULE6: global control settings apply to all eight channels at once.
// RULE7: global bit 7 makes phase address increment after each access.
// RULE8: software sets global bit 7 before enabling the waveform table.
// RULE9: global bit 6 enables ais insertion on loss of signal, all paths; the code inserts only in the receive path (rx_ais_insert).
// RULE10: software writes zero to reserved global bit 5.
// RULE11: global bit 4 zero picks b8zs/hdb3, one picks ami.
// RULE12: global bit 3 sets attenuator fifo to 32 or 64 bits.
// RULE13: global bit 2 selects low or high attenuator corner frequency.
// RULE14: position 01 transmit, 10 disabled, 11 receive path.
// RULE15: monitor low nibble picks observed rx/tx channel, zero disables.
// RULE16: reserved global bits read zero and steer nothing.
`timescale 1ns/1ps
`include "occr_consts.vh"
module occr_regs
#(
  parameter NCH = 8
)
(
  input wire mclk,
  input wire rst,
  input wire [7:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire cpu_wr,
  input wire cpu_rd,
  output reg [7:0] cpu_rdata,
  input wire e1_mode_pin,
  input wire [NCH-1:0] los,
  output wire [NCH-1:0] loopback_en,
  output wire [NCH-1:0] los_std_etsi,
  output wire [NCH-1:0] transmit_all_ones,
  output wire [NCH-1:0] rx_ais_insert,
  output wire waveform_auto_inc,
  output wire line_code_ami,
  output wire [6:0] ja_fifo_depth,
  output wire ja_corner_high,
  output wire ja_in_tx,
  output wire ja_in_rx,
  output wire mon_enable,
  output wire mon_tx,
  output wire [2:0] mon_chan,
  output wire [7:0] wave_phase_addr
);

  reg [7:0] perf_mon_q;
  reg [7:0] perf_mon_d;
  reg [7:0] loopback_q;
  reg [7:0] loopback_d;
  reg [7:0] standard_q;
  reg [7:0] standard_d;
  reg [7:0] all_ones_q;
  reg [7:0] all_ones_d;
  reg [7:0] global_q;
  reg [7:0] global_d;
  reg [7:0] phase_q;
  reg [7:0] phase_d;
  reg [7:0] rdata_d;
  reg e1_meta_q;
  reg e1_sync_q;
  wire soft_rst;
  wire phase_hit;
  wire [1:0] ja_pos;

  // bump only the phase sample field, upper address bits stay put
  function [7:0] phase_bump;
    input [7:0] addr;
    begin
      phase_bump = (addr & ~`OCCR_PHASE_MASK) |
        ((addr + 8'h01) & `OCCR_PHASE_MASK);
    end
  endfunction

  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // any write to the soft reset offset restores all defaults
  assign soft_rst = cpu_wr & hit(cpu_addr, `OCCR_SOFT_RESET); // RULE2
  assign phase_hit = (cpu_wr | cpu_rd) &
    hit(cpu_addr, `OCCR_WAVE_PHASE_ADDR);

  always @*
  begin
    perf_mon_d = perf_mon_q;
    loopback_d = loopback_q;
    standard_d = standard_q;
    all_ones_d = all_ones_q;
    global_d = global_q;
    phase_d = phase_q;
    if (cpu_wr)
    begin
      if (hit(cpu_addr, `OCCR_PERF_MON))
        perf_mon_d = cpu_wdata & `OCCR_PM_MASK;
      if (hit(cpu_addr, `OCCR_LOOPBACK_SELECT))
        loopback_d = cpu_wdata; // RULE1
      if (hit(cpu_addr, `OCCR_LOSS_ALARM_STANDARD_SELECT))
        standard_d = cpu_wdata; // RULE4
      if (hit(cpu_addr, `OCCR_AUTO_ALL_ONES_ENABLE))
        all_ones_d = cpu_wdata; // RULE5
      // reserved bit is never stored, so it cannot steer anything
      if (hit(cpu_addr, `OCCR_GLOBAL_CONTROL))
        global_d = cpu_wdata & `OCCR_GC_MASK; // RULE16
    end
    if (phase_hit)
    begin
      // a write lands first; the bump models the post-access step
      if (cpu_wr)
        phase_d = cpu_wdata;
      if (global_q[`OCCR_GC_AUTO_INC])
        phase_d = phase_bump(cpu_wr ? cpu_wdata : phase_q); // RULE7
    end
  end

  always @*
  begin
    rdata_d = 8'h00;
    case (cpu_addr)
      `OCCR_PERF_MON: rdata_d = perf_mon_q;
      `OCCR_LOOPBACK_SELECT: rdata_d = loopback_q;
      `OCCR_LOSS_ALARM_STANDARD_SELECT: rdata_d = standard_q;
      `OCCR_AUTO_ALL_ONES_ENABLE: rdata_d = all_ones_q;
      `OCCR_GLOBAL_CONTROL: rdata_d = global_q & `OCCR_GC_MASK; // RULE16
      `OCCR_WAVE_PHASE_ADDR: rdata_d = phase_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge mclk)
  begin
    if (rst || soft_rst)
    begin
      perf_mon_q <= `OCCR_REG_RESET; // RULE2
      loopback_q <= `OCCR_REG_RESET; // RULE2
      standard_q <= `OCCR_REG_RESET; // RULE2
      all_ones_q <= `OCCR_REG_RESET; // RULE2
      global_q <= `OCCR_REG_RESET; // RULE2
      phase_q <= `OCCR_REG_RESET; // RULE2
    end
    else
    begin
      perf_mon_q <= perf_mon_d;
      loopback_q <= loopback_d;
      standard_q <= standard_d;
      all_ones_q <= all_ones_d;
      global_q <= global_d;
      phase_q <= phase_d;
    end
  end

  // read data is sampled before the same cycle's write takes effect
  always @(posedge mclk)
  begin
    if (rst)
      cpu_rdata <= 8'h00;
    else if (cpu_rd)
      cpu_rdata <= rdata_d;
  end

  // the mode strap comes from a pin and crosses into mclk
  always @(posedge mclk)
  begin
    if (rst)
    begin
      e1_meta_q <= 1'b0;
      e1_sync_q <= 1'b0;
    end
    else
    begin
      e1_meta_q <= e1_mode_pin;
      e1_sync_q <= e1_meta_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : ch
      occr_chan u_chan
      (
        .mclk(mclk),
        .rst(rst),
        .e1_mode(e1_sync_q),
        .loopback_bit(loopback_q[g]),
        .standard_bit(standard_q[g]),
        .all_ones_bit(all_ones_q[g]),
        .rx_alarm_insert_en(global_q[`OCCR_GC_RX_ALARM_INSERT_EN]), // RULE6
        .los(los[g]),
        .loopback_en(loopback_en[g]),
        .los_std_etsi(los_std_etsi[g]),
        .transmit_all_ones(transmit_all_ones[g]),
        .rx_ais_insert(rx_ais_insert[g])
      );
    end
  endgenerate

  // global outputs are single shared wires seen by every channel
  assign waveform_auto_inc = global_q[`OCCR_GC_AUTO_INC]; // RULE7 RULE6
  assign line_code_ami = global_q[`OCCR_GC_LINE_CODE_SELECT]; // RULE11
  assign ja_fifo_depth = global_q[`OCCR_GC_FIFO_LEN] ?
    `OCCR_FIFO_LONG : `OCCR_FIFO_SHORT; // RULE12
  // corner value itself depends on e1/t1 mode in the attenuator
  assign ja_corner_high = global_q[`OCCR_GC_JA_CORNER_SEL]; // RULE13
  assign ja_pos = {global_q[`OCCR_GC_JA_POS_HI],
    global_q[`OCCR_GC_JA_POS_LO]};
  // code 00 is left unplaced, treated as neither path
  assign ja_in_tx = (ja_pos == `OCCR_JA_POS_TX); // RULE14
  assign ja_in_rx = (ja_pos == `OCCR_JA_POS_RX); // RULE14

  // codes x000 disable, low three bits name channel 1 to 7
  assign mon_chan = perf_mon_q[2:0]; // RULE15
  assign mon_enable = (perf_mon_q[2:0] != 3'b000); // RULE15
  assign mon_tx = perf_mon_q[`OCCR_PM_TX_BIT]; // RULE15

  assign wave_phase_addr = phase_q;

endmodule

// ===== verification/occr_regs_asserts.sv
`timescale 1ns/1ps
module occr_regs_asserts
(
  input wire mclk,
  input wire rst,
  input wire [7:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire cpu_wr,
  input wire e1_mode_pin,
  input wire [7:0] los,
  input wire [7:0] loopback_en,
  input wire [7:0] los_std_etsi,
  input wire [7:0] transmit_all_ones,
  input wire [7:0] rx_ais_insert,
  input wire waveform_auto_inc,
  input wire line_code_ami,
  input wire [6:0] ja_fifo_depth,
  input wire ja_corner_high,
  input wire ja_in_tx,
  input wire ja_in_rx,
  input wire [7:0] wave_phase_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire gw = cpu_wr && cpu_addr == 8'h0F;
  loopback_set_a: assert property (cpu_wr && cpu_addr == 8'h0C
    |-> ##2 loopback_en == $past(cpu_wdata, 2)) else $error("loopback");
  std_t1_a: assert property (!e1_mode_pin [*4]
    |-> los_std_etsi == 8'h00) else $error("standard in t1");
  all_ones_a: assert property (
    (transmit_all_ones & ~$past(los)) == 8'h00) else $error("all ones");
  ais_all_a: assert property (rx_ais_insert == 8'h00 ||
    rx_ais_insert == $past(los)) else $error("ais insert");
  gc_fields_a: assert property (gw |=>
    {waveform_auto_inc, line_code_ami, ja_corner_high, ja_fifo_depth} ==
    {$past(cpu_wdata[7]), $past(cpu_wdata[4]), $past(cpu_wdata[2]),
    $past(cpu_wdata[3]) ? 7'h40 : 7'h20}) else $error("global fields");
  ja_pos_a: assert property (gw |=> {ja_in_tx, ja_in_rx} ==
    {$past(cpu_wdata[1:0]) == 2'b01, $past(cpu_wdata[1:0]) == 2'b11})
    else $error("ja position");
  soft_rst_a: assert property (cpu_wr && cpu_addr == 8'h0A
    |=> ja_fifo_depth == 7'h20 ##1 loopback_en == 8'h00)
    else $error("soft reset");
  phase_inc_a: assert property (cpu_wr && cpu_addr == 8'h17 &&
    waveform_auto_inc |=> wave_phase_addr == {$past(cpu_wdata[7:5]),
    $past(cpu_wdata[4:0]) + 5'h01}) else $error("phase increment");
  cover property (cpu_wr && cpu_addr == 8'h17 && waveform_auto_inc);
  cover property (rx_ais_insert != 8'h00);
  cover property (ja_in_rx);
endmodule
bind occr_regs occr_regs_asserts u_chk (.mclk(mclk), .rst(rst),
  .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
  .e1_mode_pin(e1_mode_pin), .los(los), .loopback_en(loopback_en),
  .los_std_etsi(los_std_etsi), .transmit_all_ones(transmit_all_ones),
  .rx_ais_insert(rx_ais_insert), .waveform_auto_inc(waveform_auto_inc),
  .line_code_ami(line_code_ami), .ja_fifo_depth(ja_fifo_depth),
  .ja_corner_high(ja_corner_high), .ja_in_tx(ja_in_tx),
  .ja_in_rx(ja_in_rx), .wave_phase_addr(wave_phase_addr));

// ===== verification/occr_host.sv
`timescale 1ns/1ps
module occr_host
(
  input wire mclk,
  output reg [7:0] cpu_addr,
  output reg [7:0] cpu_wdata,
  output reg cpu_wr,
  output reg cpu_rd,
  input wire [7:0] cpu_rdata
);
  initial
  begin
    {cpu_addr, cpu_wdata, cpu_wr, cpu_rd} = 18'h0_0000;
  end
  // released lines flip so a stale address or data cannot pass as valid
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      {cpu_addr, cpu_wdata, cpu_wr} <= {a, d, 1'b1};
      @(posedge mclk);
      {cpu_addr, cpu_wdata, cpu_wr} <= {~a, ~d, 1'b0};
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge mclk);
      {cpu_addr, cpu_rd} <= {a, 1'b1};
      @(posedge mclk);
      {cpu_addr, cpu_rd} <= {~a, 1'b0};
      @(posedge mclk);
      d = cpu_rdata;
    end
  endtask
  task gw(input [7:0] d);
    wr(8'h0F, d & 8'hDF);
  endtask
endmodule

// ===== verification/occr_regs_tb.sv
`timescale 1ns/1ps
module occr_regs_tb;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg e1 = 1'b0;
  reg [7:0] los = 8'h00;
  reg [7:0] d;
  wire [7:0] a, wd, rdat, lb, std, tao, ais, wpa;
  wire wr, rd, winc, ami, jch, jtx, jrx, men, mtx;
  wire [6:0] fifo;
  wire [2:0] mch;
  integer err_count = 0;
  integer checked = 0;
  integer i;
  always #12.5 mclk = ~mclk;
  occr_host h (.mclk(mclk), .cpu_addr(a), .cpu_wdata(wd), .cpu_wr(wr),
    .cpu_rd(rd), .cpu_rdata(rdat));
  occr_regs uut (.mclk(mclk), .rst(rst), .cpu_addr(a), .cpu_wdata(wd),
    .cpu_wr(wr), .cpu_rd(rd), .cpu_rdata(rdat), .e1_mode_pin(e1),
    .los(los), .loopback_en(lb), .los_std_etsi(std),
    .transmit_all_ones(tao), .rx_ais_insert(ais), .waveform_auto_inc(winc),
    .line_code_ami(ami), .ja_fifo_depth(fifo), .ja_corner_high(jch),
    .ja_in_tx(jtx), .ja_in_rx(jrx), .mon_enable(men), .mon_tx(mtx),
    .mon_chan(mch), .wave_phase_addr(wpa));
  // wide enough for the ten bit channel and position group
  task chk(input [15:0] g, input [15:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task complete_run;
    begin
      if (err_count == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task t_reset;
    for (i = 11; i < 16; i = i + 1)
    begin
      h.rd(i[7:0], d);
      chk(d | lb | std | tao | ais, 8'h00);
      chk({1'b0, fifo}, 8'h20);
    end
  endtask
  task t_chan;
    begin
      h.wr(8'h0C, 8'h5A);
      h.wr(8'h0D, 8'h3C);
      h.wr(8'h0E, 8'h0F);
      los <= 8'h33;
      repeat (3) @(posedge mclk);
      chk(lb, 8'h5A);
      chk(tao, 8'h03);
      chk(std, 8'h00);
      e1 <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(std, 8'h3C);
      e1 <= 1'b0;
    end
  endtask
  task t_gc;
    begin
      los <= 8'hA5;
      h.wr(8'h0F, 8'hFF);
      h.rd(8'h0F, d);
      chk(d, 8'hDF);
      chk(ais, 8'hA5);
      chk({winc, ami, jch, jtx, jrx, fifo[6:4]}, 8'hEC);
      h.rd(8'h20, d);
      chk(d, 8'h00);
      for (i = 0; i < 4; i = i + 1)
      begin
        h.gw(i[7:0]);
        repeat (2) @(posedge mclk);
        chk({ais, jtx, jrx}, {8'h00, i == 1, i == 3});
        chk({1'b0, fifo}, 8'h20);
      end
      los <= 8'h00;
    end
  endtask
  task t_phase;
    begin
      h.gw(8'h80);
      h.wr(8'h17, 8'h3F);
      h.rd(8'h17, d);
      chk(d, 8'h20);
      chk(wpa, 8'h21);
      h.gw(8'h00);
      h.wr(8'h17, 8'h05);
      h.rd(8'h17, d);
      chk(d, 8'h05);
      chk(wpa, 8'h05);
    end
  endtask
  task t_mon;
    for (i = 0; i < 16; i = i + 1)
    begin
      h.wr(8'h0B, i[7:0]);
      @(posedge mclk);
      chk({men, mtx, 3'b000, mch},
        {i[2:0] != 3'b000, i[3], 3'b000, i[2:0]});
    end
  endtask
  task t_soft;
    begin
      h.wr(8'h0C, 8'hFF);
      h.wr(8'h0A, 8'h5A);
      h.rd(8'h0C, d);
      chk(d | lb, 8'h00);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_chan;
    t_gc;
    t_phase;
    t_mon;
    t_soft;
    complete_run;
  end
  // the sequence needs about 130 cycles, so this leaves wide margin
  initial
  begin
    #50000;
    err_count = err_count + 1;
    complete_run;
  end
endmodule
